// >>> design/sc_dram_pkg.sv
package sc_dram_pkg;
  localparam int CLK_MHZ = 10;
  localparam int CLK_NS = 1000 / CLK_MHZ;
  localparam int POWERUP_US = 200;
  localparam int INIT_REFRESHES = 8;
  localparam int REFRESH_MS = 4;
  localparam int ROWS = 256;
  localparam int ROW_ACCESS_NS = 150;
  localparam int ROW_PRECHARGE_NS = 100;
  localparam int READ_HOLD_AFTER_ROW_NS = 10;
  localparam int ROW_TO_WRITE_DELAY_NS = 185;
  localparam int WRITE_PULSE_NS = 25;
  function automatic int ceil_cycles(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS < 1 ? 1 : (ns + CLK_NS - 1) / CLK_NS;
  endfunction : ceil_cycles
  localparam int POWERUP_CYC = POWERUP_US * 1000 / CLK_NS;
  localparam int REFRESH_INTERVAL_CYC = REFRESH_MS * 1000000 / CLK_NS / ROWS;
  localparam int ACCESS_CYC = ceil_cycles(ROW_ACCESS_NS);
  localparam int PRECHARGE_CYC = ceil_cycles(ROW_PRECHARGE_NS);
  localparam int RMW_CYC = ceil_cycles(ROW_TO_WRITE_DELAY_NS);
  localparam int WRITE_CYC = ceil_cycles(WRITE_PULSE_NS);
  localparam int HOLD_CYC = ceil_cycles(READ_HOLD_AFTER_ROW_NS);
  // Read data must cross the three pin flops and the agree stage before it is sampled
  localparam int SYNC_CYC = 3;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_RMW} op_kind_t;
  typedef struct packed {
    logic row_strobe_b;
    logic column_strobe_b;
    logic write_enable_b;
    logic output_enable_b;
    logic [7:0] multiplexed_address_pins;
  } strobe_bus_t;
endpackage : sc_dram_pkg

// >>> design/sc_dram_host.sv
`timescale 1ns/1ns
`default_nettype none
module sc_dram_host
  import sc_dram_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int REFRESH_CYCLES = REFRESH_INTERVAL_CYC,
  parameter bit USE_COUNTER_REFRESH = 1'b1
)(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire op_kind_t req_op,
  input wire logic [15:0] req_addr,
  input wire logic [3:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [3:0] rsp_rdata,
  output logic init_done,
  output strobe_bus_t pins,
  output logic [3:0] dq_out,
  output logic dq_oe,
  input wire logic [3:0] dq_in
);
  typedef enum {S_PAUSE, S_REF_SETUP, S_REF_ROW, S_PRE, S_IDLE, S_ROW, S_COL, S_WR,
    S_DONE} state_t;
  state_t state, next_state;
  logic [31:0] cnt, next_cnt, ref_cnt, next_ref_cnt;
  logic [3:0] inits, next_inits;
  logic [7:0] ref_row, next_ref_row;
  logic ref_due, next_ref_due;
  op_kind_t op, next_op;
  logic [15:0] addr, next_addr;
  logic [3:0] wdata, next_wdata, rdata, next_rdata;
  strobe_bus_t next_pins;
  logic next_oe, next_rsp_valid;
  logic [3:0] s1, s2, s3, dq_sync, next_dq_sync;

  // Three-stage synchroniser on the data pins; accepted when stages two and three agree
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
      dq_sync <= 4'h0;
    end
    else
    begin
      s1 <= dq_in;
      s2 <= s1;
      s3 <= s2;
      dq_sync <= next_dq_sync;
    end
  end
  always_comb
  begin
    next_dq_sync = (s2 == s3) ? s3 : dq_sync;
  end

  always_comb
  begin
    next_state = state;
    next_cnt = (cnt == 32'h0) ? 32'h0 : cnt - 32'h1;
    next_ref_cnt = (ref_cnt == 32'h0) ? 32'h0 : ref_cnt - 32'h1;
    next_ref_due = ref_due || (ref_cnt == 32'h0);
    next_inits = inits;
    next_ref_row = ref_row;
    next_op = op;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_pins = pins;
    next_oe = dq_oe;
    next_rsp_valid = 1'b0;
    case (state)
      S_PAUSE:
      begin
        if (cnt == 32'h0)
        begin
          next_state = S_REF_SETUP;
          next_cnt = 32'(HOLD_CYC);
          if (USE_COUNTER_REFRESH)
            next_pins.column_strobe_b = 1'b0;
          else
            next_pins.multiplexed_address_pins = ref_row;
        end
      end
      S_REF_SETUP:
      begin
        if (cnt == 32'h0)
        begin
          next_pins.row_strobe_b = 1'b0;
          next_cnt = 32'(ACCESS_CYC);
          next_state = S_REF_ROW;
        end
      end
      S_REF_ROW:
      begin
        if (cnt == 32'h0)
        begin
          next_pins.row_strobe_b = 1'b1;
          next_pins.column_strobe_b = 1'b1;
          next_ref_row = ref_row + 8'h1;
          next_cnt = 32'(PRECHARGE_CYC);
          if (inits != 4'(INIT_REFRESHES))
            next_inits = inits + 4'h1;
          next_state = S_PRE;
        end
      end
      S_PRE:
      begin
        if (cnt == 32'h0)
          next_state = (inits == 4'(INIT_REFRESHES)) ? S_IDLE : S_PAUSE;
      end
      S_IDLE:
      begin
        if (ref_due)
        begin
          next_ref_due = 1'b0;
          next_ref_cnt = 32'(REFRESH_CYCLES);
          next_state = S_PAUSE;
        end
        else if (req_valid)
        begin
          next_op = req_op;
          next_addr = req_addr;
          next_wdata = req_wdata;
          next_pins.multiplexed_address_pins = req_addr[15:8];
          next_pins.row_strobe_b = 1'b0;
          next_pins.write_enable_b = 1'b1;
          next_pins.output_enable_b = (req_op == OP_WRITE);
          next_cnt = 32'(HOLD_CYC);
          next_state = S_ROW;
        end
      end
      S_ROW:
      begin
        // Write data stands on the pins a cycle before write enable falls
        if (op == OP_WRITE)
          next_oe = 1'b1;
        if (cnt == 32'h0)
        begin
          next_pins.multiplexed_address_pins = addr[7:0];
          next_pins.column_strobe_b = 1'b0;
          // Wait out the synchroniser too, or the sample would see the idle bus
          next_cnt = 32'((op == OP_RMW ? RMW_CYC : ACCESS_CYC) + SYNC_CYC);
          next_state = S_COL;
          if (op == OP_WRITE)
          begin
            next_pins.write_enable_b = 1'b0;
            next_cnt = 32'(WRITE_CYC);
          end
        end
      end
      S_COL:
      begin
        // Address stays put until data is valid, so no column latch is assumed
        if (cnt == 32'h0)
        begin
          if (op == OP_WRITE)
            next_state = S_DONE;
          else
          begin
            next_rdata = dq_sync;
            next_rsp_valid = (op == OP_READ);
            next_state = (op == OP_RMW) ? S_WR : S_DONE;
            if (op == OP_RMW)
            begin
              next_pins.output_enable_b = 1'b1;
              next_pins.write_enable_b = 1'b0;
              next_oe = 1'b1;
              next_cnt = 32'(WRITE_CYC);
              next_rsp_valid = 1'b1;
            end
          end
          if (op == OP_WRITE)
            next_oe = 1'b0;
        end
        else if (op == OP_WRITE)
          next_oe = 1'b1;
      end
      S_WR:
      begin
        if (cnt == 32'h0)
          next_state = S_DONE;
      end
      S_DONE:
      begin
        // Write enable is left as it is here; after a write it stays low until the next access raises it as the row strobe falls
        next_pins.row_strobe_b = 1'b1;
        next_pins.column_strobe_b = 1'b1;
        next_pins.output_enable_b = 1'b1;
        next_oe = 1'b0;
        next_cnt = 32'(PRECHARGE_CYC);
        next_state = S_PRE;
      end
      default:
        next_state = S_PAUSE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= S_PAUSE;
      cnt <= 32'(POWERUP_CYCLES);
      ref_cnt <= 32'(REFRESH_CYCLES);
      ref_due <= 1'b0;
      inits <= 4'h0;
      ref_row <= 8'h0;
      op <= OP_READ;
      addr <= 16'h0;
      wdata <= 4'h0;
      rdata <= 4'h0;
      pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 8'h0};
      dq_oe <= 1'b0;
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      init_done <= 1'b0;
      rsp_rdata <= 4'h0;
      dq_out <= 4'h0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      ref_cnt <= next_ref_cnt;
      ref_due <= next_ref_due;
      inits <= next_inits;
      ref_row <= next_ref_row;
      op <= next_op;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      pins <= next_pins;
      dq_oe <= next_oe;
      rsp_valid <= next_rsp_valid;
      req_ready <= (next_state == S_IDLE) && !next_ref_due;
      init_done <= (next_inits == 4'(INIT_REFRESHES));
      rsp_rdata <= next_rdata;
      dq_out <= next_wdata;
    end
  end

  AST_PAUSE_STROBES_HIGH: assert property (@(posedge mclk) disable iff (!rst_b)
    state == S_PAUSE |-> pins.row_strobe_b && pins.column_strobe_b)
    else $error("strobes low during pause");
  AST_NO_DRIVE_OE_LOW: assert property (@(posedge mclk) disable iff (!rst_b)
    dq_oe |-> pins.output_enable_b)
    else $error("data driven while output enable low");
  AST_INIT_BEFORE_USE: assert property (@(posedge mclk) disable iff (!rst_b)
    state == S_ROW |-> inits == 4'(INIT_REFRESHES))
    else $error("access before initial refreshes");
  AST_RAS_RELEASE: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(pins.row_strobe_b) && op == OP_READ |-> pins.write_enable_b)
    else $error("write enable low at row strobe rise");
  AST_CBR_SETUP: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(pins.row_strobe_b) && state == S_REF_ROW |-> $past(pins.column_strobe_b)
      == !USE_COUNTER_REFRESH)
    else $error("refresh strobe order wrong");
  AST_ROW_WRAP: assert property (@(posedge mclk) disable iff (!rst_b)
    $changed(ref_row) |-> ref_row == $past(ref_row) + 8'h1)
    else $error("refresh row step wrong");
  AST_READ_RESP: assert property (@(posedge mclk) disable iff (!rst_b)
    state == S_COL && op == OP_READ && cnt == 32'h0 |=> rsp_valid)
    else $error("read response missing");
  AST_WE_HIGH_READ: assert property (@(posedge mclk) disable iff (!rst_b)
    state == S_COL && op == OP_READ |-> pins.write_enable_b)
    else $error("write enable low in read");
  AST_WRITE_DATA_SET: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(pins.write_enable_b) |-> dq_oe && pins.output_enable_b)
    else $error("write enable fell without data driven");
endmodule : sc_dram_host
`default_nettype wire

// >>> tb/sc_dram_model.sv
`timescale 1ns/1ns
`default_nettype none
module sc_dram_model
  import sc_dram_pkg::*;
#(
  parameter int ROW_ACC_NS = 150,
  parameter int COL_ACC_NS = 35,
  parameter int WRITE_NS = 25
)(
  input wire strobe_bus_t pins,
  input wire logic [3:0] dq_bus,
  output logic [3:0] dev_dq,
  output logic dev_en
);
  logic [3:0] mem [0:65535];
  logic [7:0] row = 8'h00;
  logic [7:0] ref_row = 8'h00;
  logic row_ok = 1'b0;
  logic col_ok = 1'b0;
  logic cbr = 1'b0;
  int cbr_cnt = 0;
  int ras_only_cnt = 0;
  realtime first_row = 0;
  // Transport delays, so a short precharge cannot carry an old access over
  always @(pins.row_strobe_b) row_ok <= #(ROW_ACC_NS) !pins.row_strobe_b;
  always @(pins.column_strobe_b) col_ok <= #(COL_ACC_NS) !pins.column_strobe_b;
  assign dev_en = !pins.row_strobe_b && row_ok && !pins.column_strobe_b && col_ok
    && !pins.output_enable_b && pins.write_enable_b && !cbr;
  assign dev_dq = mem[{row, pins.multiplexed_address_pins}];
  always @(negedge pins.row_strobe_b)
  begin
    if (first_row == 0)
      first_row = $realtime;
    if (!pins.column_strobe_b)
    begin
      cbr = 1'b1;
      ref_row = ref_row + 8'h01;
      cbr_cnt++;
    end
    else
    begin
      row = pins.multiplexed_address_pins;
      ras_only_cnt++;
    end
  end
  always @(posedge pins.row_strobe_b) cbr = 1'b0;
  // The blocking wait drops any write that arrives while one is in progress
  always @(negedge pins.column_strobe_b or negedge pins.write_enable_b)
  begin
    if (!pins.row_strobe_b && !cbr && !pins.column_strobe_b && !pins.write_enable_b)
    begin
      #1;
      mem[{row, pins.multiplexed_address_pins}] = dq_bus;
      #(WRITE_NS);
    end
  end
endmodule : sc_dram_model
`default_nettype wire

// >>> tb/sc_dram_host_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module sc_dram_host_tb;
  import sc_dram_pkg::*;
  localparam int PWR = 20;
  localparam int REF = 50;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  op_kind_t req_op = OP_READ;
  logic [15:0] req_addr = 16'h0000;
  logic [3:0] req_wdata = 4'h0;
  logic req_ready, rsp_valid, init_done, dq_oe, dev_en;
  logic [3:0] rsp_rdata, dq_out, dev_dq, dq_bus;
  logic [3:0] dq_last = 4'h0;
  strobe_bus_t pins;
  logic alt_rsp_valid, alt_dq_oe, alt_dev_en;
  logic [3:0] alt_rsp_rdata, alt_dq_out, alt_dev_dq, alt_dq_bus;
  logic [3:0] alt_dq_last = 4'h0;
  strobe_bus_t alt_pins;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  realtime rst_rel = 0;

  sc_dram_host #(.POWERUP_CYCLES(PWR), .REFRESH_CYCLES(REF), .USE_COUNTER_REFRESH(1'b1)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .init_done(init_done), .pins(pins), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_bus));
  sc_dram_model u_dev (.pins(pins), .dq_bus(dq_bus), .dev_dq(dev_dq), .dev_en(dev_en));
  // Second host on the same requests runs the row-only refresh mode in lockstep
  sc_dram_host #(.POWERUP_CYCLES(PWR), .REFRESH_CYCLES(REF), .USE_COUNTER_REFRESH(1'b0)) u_alt (
    .mclk(mclk), .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(), .rsp_valid(alt_rsp_valid),
    .rsp_rdata(alt_rsp_rdata), .init_done(), .pins(alt_pins), .dq_out(alt_dq_out),
    .dq_oe(alt_dq_oe), .dq_in(alt_dq_bus));
  sc_dram_model u_alt_dev (.pins(alt_pins), .dq_bus(alt_dq_bus), .dev_dq(alt_dev_dq),
    .dev_en(alt_dev_en));
  assign alt_dq_bus = alt_dq_oe ? alt_dq_out : (alt_dev_en ? alt_dev_dq : ~alt_dq_last);
  always @(posedge mclk) alt_dq_last <= alt_dq_bus;

  // No pull on the data lines: an undriven bus shows a changing pattern
  assign dq_bus = dq_oe ? dq_out : (dev_en ? dev_dq : ~dq_last);
  always @(posedge mclk) dq_last <= dq_bus;

  initial forever #50 mclk = ~mclk;

  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      stop_test();
    end
  end

  always @(negedge mclk)
  begin
    if (rst_b && dq_oe)
    begin
      `CHK(pins.output_enable_b, 1'b1)
      `CHK(dev_en, 1'b0)
    end
  end

  task automatic xfer(op_kind_t op, logic [15:0] a, logic [3:0] d, logic [3:0] exp);
    int n;
    n = 0;
    @(negedge mclk);
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_wdata = d;
    while (!req_ready && n < 300)
    begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    req_valid = 1'b0;
    n = 0;
    if (op != OP_WRITE)
    begin
      while (!rsp_valid && n < 40)
      begin
        @(negedge mclk);
        n++;
      end
      `CHK(rsp_valid, 1'b1)
      `CHK(rsp_rdata, exp)
      `CHK(alt_rsp_valid, 1'b1)
      `CHK(alt_rsp_rdata, exp)
    end
    n = 0;
    while (!req_ready && n < 300)
    begin
      @(negedge mclk);
      n++;
    end
    if (op != OP_READ)
    begin
      `CHK(u_dev.mem[a], d)
      `CHK(u_alt_dev.mem[a], d)
    end
  endtask : xfer

  task automatic t_init();
    int n;
    n = 0;
    while (!init_done && n < 2000)
    begin
      @(negedge mclk);
      n++;
    end
    `CHK(init_done, 1'b1)
    `CHK(u_dev.cbr_cnt >= INIT_REFRESHES, 1'b1)
    `CHK(u_dev.ras_only_cnt, 0)
    `CHK(u_alt_dev.ras_only_cnt, INIT_REFRESHES)
    `CHK(u_alt_dev.cbr_cnt, 0)
    `CHK(u_dev.first_row - rst_rel >= PWR * 100.0, 1'b1)
  endtask : t_init

  task automatic t_rw();
    logic [15:0] a [6] = '{16'h0000, 16'h00FF, 16'hFF00, 16'hFFFF, 16'h1234, 16'hA55A};
    foreach (a[i]) xfer(OP_WRITE, a[i], 4'(i + 3), 4'h0);
    foreach (a[i]) xfer(OP_READ, a[i], 4'h0, 4'(i + 3));
  endtask : t_rw

  task automatic t_rmw();
    xfer(OP_RMW, 16'h1234, 4'hE, 4'h7);
    xfer(OP_RMW, 16'hFFFF, 4'h1, 4'h6);
    xfer(OP_READ, 16'h1234, 4'h0, 4'hE);
  endtask : t_rmw

  task automatic t_refresh();
    int c0;
    int r0;
    c0 = u_dev.cbr_cnt;
    r0 = u_alt_dev.ras_only_cnt;
    repeat (REF * 300) @(negedge mclk);
    `CHK(u_dev.cbr_cnt - c0 >= 250, 1'b1)
    `CHK(u_alt_dev.ras_only_cnt - r0 >= 250, 1'b1)
    `CHK(u_dev.ref_row, 8'(u_dev.cbr_cnt))
    xfer(OP_READ, 16'hA55A, 4'h0, 4'h8);
  endtask : t_refresh

  initial
  begin
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    rst_rel = $realtime;
    t_init();
    t_rw();
    t_rmw();
    t_refresh();
    stop_test();
  end
endmodule : sc_dram_host_tb
`default_nettype wire
